// *** src/pwm_clock_divider.sv ***
// Source oscillator select and 1/2/4/8 divider producing the counter tick
`timescale 1ns/100ps
`include "pwm_map.svh"

module pwm_clock_divider
  import pwm_pkg::*;
(
  input  wire logic       mclk,         // System clock
  input  wire logic       rst,          // Asynchronous reset, active high
  input  wire logic       run,          // Modulator enabled
  input  wire logic       src_sel,      // 0 fast oscillator, 1 slow oscillator
  input  wire logic [1:0] div_sel,      // Division code
  input  wire logic       fast_osc_tick, // One-cycle pulse per fast oscillator period
  input  wire logic       slow_osc_tick, // One-cycle pulse per slow oscillator period
  output logic            cnt_tick      // One-cycle pulse per divided counter clock
);

  div_state_s state_ff;
  div_state_s nxt_state;
  logic       src_tick;

  function automatic logic [2:0] div_mask(input logic [1:0] code);
    case (code)
      `DIV_BY_1: div_mask = 3'h0;
      `DIV_BY_2: div_mask = 3'h1;
      `DIV_BY_4: div_mask = 3'h3;
      default:   div_mask = 3'h7;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    src_tick  = src_sel ? slow_osc_tick : fast_osc_tick;
    nxt_state = state_ff;
    nxt_state.tick = 1'b0;
    if (!run) begin
      nxt_state.cnt = 3'h0;
    end else if (src_tick) begin
      // Tick when the low bits selected by the code are all ones
      nxt_state.tick = ((state_ff.cnt & div_mask(div_sel)) == div_mask(div_sel));
      nxt_state.cnt  = 3'(state_ff.cnt + 3'h1);
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign cnt_tick = state_ff.tick;

  ////////////////////////////////////////////////////////////////////////////////
  chk_div_by8: assert property (@(posedge mclk) disable iff (rst)
    run && div_sel == `DIV_BY_8 && src_tick && state_ff.cnt != 3'h7 |=> !cnt_tick)
    else $error("divide by 8 ticked early");
  chk_div_by1: assert property (@(posedge mclk) disable iff (rst)
    run && div_sel == `DIV_BY_1 && src_tick |=> cnt_tick)
    else $error("undivided source missed a tick");

endmodule

// *** src/pwm_map.svh ***
// Register offsets, field positions, reset values and divider codes of the modulator
`ifndef PWM_MAP_SVH
`define PWM_MAP_SVH

`define ADDR_W              2
`define DATA_W              8
`define OFS_CONTROL         2'h0
`define OFS_DUTY            2'h1
`define OFS_PERIOD          2'h2

`define CTRL_DIV_HI         7
`define CTRL_DIV_LO         6
`define CTRL_SRC_BIT        5
`define CTRL_EN_BIT         4
`define CTRL_TRUE_OE_BIT    3
`define CTRL_COMP_OE_BIT    2
`define CTRL_WR_MASK        8'hfc

`define RST_CONTROL         8'h00
`define RST_DUTY            8'h00
`define RST_PERIOD          8'h00

`define DIV_BY_1            2'h0
`define DIV_BY_2            2'h1
`define DIV_BY_4            2'h2
`define DIV_BY_8            2'h3

`endif

// *** src/pwm_modulator.sv ***
// Complementary 8-bit pulse width modulator with register port and gate drive
`timescale 1ns/100ps
`include "pwm_map.svh"

module pwm_modulator
  import pwm_pkg::*;
(
  input  wire logic                 mclk,          // System clock, 10 MHz
  input  wire logic                 rst,           // Asynchronous reset, active high
  input  wire logic [`ADDR_W-1:0]   addr,          // Register address
  input  wire logic [`DATA_W-1:0]   wdata,         // Write data
  input  wire logic                 wr_en,         // Write strobe
  input  wire logic                 rd_en,         // Read strobe
  output logic      [`DATA_W-1:0]   rdata,         // Read data, cycle after strobe
  input  wire logic                 fast_osc_tick, // Fast oscillator pulse
  input  wire logic                 slow_osc_tick, // Slow oscillator pulse
  output pins_s                     pins           // Pin levels, enables and gate
);

  pwm_state_s state_ff;
  pwm_state_s nxt_state;
  logic       cnt_tick;
  logic       wrap;
  logic       wave;

  ////////////////////////////////////////////////////////////////////////////////
  // Counter clock generation
  pwm_clock_divider u_div (
    .mclk          (mclk),
    .rst           (rst),
    .run           (state_ff.ctrl.en),
    .src_sel       (state_ff.ctrl.src),
    .div_sel       (state_ff.ctrl.div),
    .fast_osc_tick (fast_osc_tick),
    .slow_osc_tick (slow_osc_tick),
    .cnt_tick      (cnt_tick)
  );

  function automatic logic [7:0] ctrl_word(input ctrl_s c);
    ctrl_word = {c.div, c.src, c.en, c.true_oe, c.comp_oe, 2'b00};
  endfunction

  function automatic logic wave_level(input logic [7:0] cnt, input logic [7:0] duty,
                                      input logic [7:0] period);
    if (duty == 8'h00) begin
      wave_level = 1'b0;
    end else if (duty >= period) begin
      wave_level = 1'b1;
    end else begin
      wave_level = (cnt < duty);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    nxt_state = state_ff;
    wrap      = cnt_tick && (state_ff.cnt >= state_ff.period_act);
    wave      = 1'b0;

    // Register writes
    if (wr_en) begin
      case (addr)
        `OFS_CONTROL: begin
          nxt_state.ctrl = ctrl_s'(wdata[`CTRL_DIV_HI:`CTRL_COMP_OE_BIT]);
        end
        `OFS_DUTY:   nxt_state.duty   = wdata;
        `OFS_PERIOD: nxt_state.period = wdata;
        default: begin
        end
      endcase
    end

    // Register reads; unmapped address reads zero
    if (rd_en) begin
      case (addr)
        `OFS_CONTROL: nxt_state.rdata = ctrl_word(state_ff.ctrl);
        `OFS_DUTY:    nxt_state.rdata = state_ff.duty;
        `OFS_PERIOD:  nxt_state.rdata = state_ff.period;
        default:      nxt_state.rdata = 8'h00;
      endcase
    end else begin
      nxt_state.rdata = 8'h00;
    end

    // Counter and shadow values
    case (state_ff.st)
      ST_IDLE: begin
        nxt_state.cnt        = 8'h00;
        nxt_state.duty_act   = state_ff.duty;
        nxt_state.period_act = state_ff.period;
        if (state_ff.ctrl.en) begin
          nxt_state.st = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!state_ff.ctrl.en) begin
          nxt_state.st  = ST_IDLE;
          nxt_state.cnt = 8'h00;
        end else if (wrap) begin
          nxt_state.cnt        = 8'h00;
          nxt_state.duty_act   = state_ff.duty;
          nxt_state.period_act = state_ff.period;
        end else if (cnt_tick) begin
          nxt_state.cnt = 8'(state_ff.cnt + 8'h01);
        end
      end
      default: begin
        nxt_state.st  = ST_IDLE;
        nxt_state.cnt = 8'h00;
      end
    endcase

    // Outputs
    if (state_ff.st == ST_RUN && state_ff.ctrl.en) begin
      wave = wave_level(state_ff.cnt, state_ff.duty_act, state_ff.period_act);
    end
    nxt_state.pins.true_o    = wave;
    nxt_state.pins.comp_o    = !wave;
    nxt_state.pins.gate      = wave;
    nxt_state.pins.true_oe_n = !(state_ff.ctrl.en && state_ff.ctrl.true_oe);
    nxt_state.pins.comp_oe_n = !(state_ff.ctrl.en && state_ff.ctrl.comp_oe);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_ff            <= '0;
      state_ff.st         <= ST_IDLE;
      state_ff.ctrl       <= ctrl_s'(6'(`RST_CONTROL >> `CTRL_COMP_OE_BIT));
      state_ff.duty       <= `RST_DUTY;
      state_ff.period     <= `RST_PERIOD;
      state_ff.pins       <= '0;
      state_ff.pins.comp_o    <= 1'b1;
      state_ff.pins.true_oe_n <= 1'b1;
      state_ff.pins.comp_oe_n <= 1'b1;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign rdata = state_ff.rdata;
  assign pins  = state_ff.pins;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  chk_cnt_idle_zero: assert property (
    !state_ff.ctrl.en |=> state_ff.cnt == 8'h00 && !state_ff.pins.true_o)
    else $error("counter or waveform active while disabled");

  chk_pins_float_off: assert property (
    !state_ff.ctrl.en |=> state_ff.pins.true_oe_n && state_ff.pins.comp_oe_n)
    else $error("pin driven while disabled");

  chk_true_oe_gate: assert property (
    state_ff.ctrl.en |=> state_ff.pins.true_oe_n == !$past(state_ff.ctrl.true_oe))
    else $error("true pin enable mismatch");

  chk_comp_oe_gate: assert property (
    state_ff.ctrl.en |=> state_ff.pins.comp_oe_n == !$past(state_ff.ctrl.comp_oe))
    else $error("complement pin enable mismatch");

  chk_full_high: assert property (
    state_ff.st == ST_RUN && state_ff.ctrl.en && state_ff.duty_act != 8'h00
      && state_ff.duty_act >= state_ff.period_act |=> state_ff.pins.true_o)
    else $error("full duty not high");

  chk_zero_low: assert property (
    state_ff.duty_act == 8'h00 |=> !state_ff.pins.true_o)
    else $error("zero duty not low");

  chk_comp_inverse: assert property (
    state_ff.pins.comp_o == !state_ff.pins.true_o)
    else $error("complement not inverse of true output");

  chk_gate_follow: assert property (
    state_ff.pins.gate == state_ff.pins.true_o)
    else $error("gate differs from true output");

  chk_shadow_hold: assert property (
    state_ff.st == ST_RUN && state_ff.ctrl.en && !wrap
      |=> $stable(state_ff.duty_act) && $stable(state_ff.period_act))
    else $error("shadow changed away from counter zero");

  chk_wrap_zero: assert property (
    state_ff.st == ST_RUN && state_ff.ctrl.en && wrap
      |=> state_ff.cnt == 8'h00 && state_ff.period_act == $past(state_ff.period))
    else $error("counter did not wrap and reload");

  chk_ctrl_low_zero: assert property (
    rd_en && addr == `OFS_CONTROL |=> rdata[1:0] == 2'b00)
    else $error("unimplemented control bits read nonzero");

  // Register port
  chk_duty_write: assert property (
    wr_en && addr == `OFS_DUTY |=> state_ff.duty == $past(wdata))
    else $error("duty write not stored");

  chk_period_write: assert property (
    wr_en && addr == `OFS_PERIOD |=> state_ff.period == $past(wdata))
    else $error("period write not stored");

  chk_ctrl_write: assert property (
    wr_en && addr == `OFS_CONTROL
      |=> state_ff.ctrl == $past(wdata[`CTRL_DIV_HI:`CTRL_COMP_OE_BIT]))
    else $error("control write not stored");

  chk_duty_readback: assert property (
    rd_en && addr == `OFS_DUTY |=> rdata == $past(state_ff.duty))
    else $error("duty read back wrong");

  chk_period_readback: assert property (
    rd_en && addr == `OFS_PERIOD |=> rdata == $past(state_ff.period))
    else $error("period read back wrong");

  chk_ctrl_readback: assert property (
    rd_en && addr == `OFS_CONTROL |=> rdata[7:2] == $past(state_ff.ctrl))
    else $error("control read back wrong");

  // Counter and waveform
  chk_run_enter: assert property (
    state_ff.st == ST_IDLE && state_ff.ctrl.en |=> state_ff.st == ST_RUN)
    else $error("modulator did not start");

  chk_stop_idle: assert property (
    state_ff.st == ST_RUN && !state_ff.ctrl.en
      |=> state_ff.st == ST_IDLE && state_ff.cnt == 8'h00)
    else $error("modulator did not stop");

  chk_cnt_step: assert property (
    state_ff.st == ST_RUN && state_ff.ctrl.en && cnt_tick && !wrap
      |=> state_ff.cnt == 8'($past(state_ff.cnt) + 8'h01))
    else $error("counter did not step on tick");

  chk_cnt_hold: assert property (
    state_ff.st == ST_RUN && state_ff.ctrl.en && !cnt_tick |=> $stable(state_ff.cnt))
    else $error("counter moved without tick");

  chk_wrap_duty: assert property (
    state_ff.st == ST_RUN && state_ff.ctrl.en && wrap
      |=> state_ff.duty_act == $past(state_ff.duty))
    else $error("duty not reloaded at wrap");

  chk_idle_shadow: assert property (
    state_ff.st == ST_IDLE
      |=> state_ff.duty_act == $past(state_ff.duty) && state_ff.period_act == $past(state_ff.period))
    else $error("shadow not following while idle");

  chk_high_start: assert property (
    state_ff.st == ST_RUN && state_ff.ctrl.en && state_ff.duty_act != 8'h00
      && state_ff.cnt == 8'h00 |=> state_ff.pins.true_o)
    else $error("waveform low at count zero");

  chk_low_at_duty: assert property (
    state_ff.st == ST_RUN && state_ff.ctrl.en && state_ff.duty_act < state_ff.period_act
      && state_ff.cnt >= state_ff.duty_act |=> !state_ff.pins.true_o)
    else $error("waveform high past duty");

  chk_gate_off: assert property (
    !state_ff.ctrl.en |=> !state_ff.pins.gate)
    else $error("gate active while disabled");

  chk_comp_high_off: assert property (
    !state_ff.ctrl.en |=> state_ff.pins.comp_o)
    else $error("complement not high while disabled");

  chk_full_comp_low: assert property (
    state_ff.st == ST_RUN && state_ff.ctrl.en && state_ff.duty_act != 8'h00
      && state_ff.duty_act >= state_ff.period_act |=> !state_ff.pins.comp_o)
    else $error("complement not low at full duty");

  chk_true_oe_off: assert property (
    !state_ff.ctrl.true_oe |=> state_ff.pins.true_oe_n)
    else $error("true pin driven with its enable clear");

  chk_comp_oe_off: assert property (
    !state_ff.ctrl.comp_oe |=> state_ff.pins.comp_oe_n)
    else $error("complement pin driven with its enable clear");

  cov_wrap: cover property (state_ff.st == ST_RUN && wrap && state_ff.period_act != 8'h00);
  cov_toggle: cover property (state_ff.pins.true_o ##[1:600] !state_ff.pins.true_o);
  cov_reload: cover property (wrap && state_ff.duty != state_ff.duty_act);
  cov_full_high: cover property (state_ff.st == ST_RUN && state_ff.duty_act >= state_ff.period_act);
  cov_slow_tick: cover property (state_ff.ctrl.en && state_ff.ctrl.src && cnt_tick);

endmodule

// *** src/pwm_pkg.sv ***
// Types shared by the modulator and its clock divider
package pwm_pkg;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_RUN  = 2'h1
  } run_state_e;

  typedef struct packed {
    logic [1:0] div;
    logic       src;
    logic       en;
    logic       true_oe;
    logic       comp_oe;
  } ctrl_s;

  typedef struct packed {
    logic true_o;
    logic true_oe_n;
    logic comp_o;
    logic comp_oe_n;
    logic gate;
  } pins_s;

  typedef struct packed {
    logic [2:0] cnt;
    logic       tick;
  } div_state_s;

  typedef struct packed {
    run_state_e st;
    ctrl_s      ctrl;
    logic [7:0] duty;
    logic [7:0] period;
    logic [7:0] duty_act;
    logic [7:0] period_act;
    logic [7:0] cnt;
    logic [7:0] rdata;
    pins_s      pins;
  } pwm_state_s;

endpackage

// *** tb/complementary_pwm_8bit_tb.sv ***
// Self-checking bench for the complementary modulator
`timescale 1ns/100ps
`include "pwm_map.svh"

module complementary_pwm_8bit_tb
  import pwm_pkg::*;
;
  logic              mclk = 1'b0;
  logic              rst = 1'b1;
  logic [`ADDR_W-1:0] addr = '0;
  logic [`DATA_W-1:0] wdata = '0;
  logic              wr_en = 1'b0;
  logic              rd_en = 1'b0;
  logic [`DATA_W-1:0] rdata;
  logic              fast_osc_tick = 1'b0;
  logic              slow_osc_tick = 1'b0;
  pins_s             pins;
  logic              true_pin;
  logic              comp_pin;
  logic              gate_line;
  logic              prev_ff = 1'b0;
  int                mismatches, checked, osc_cnt;
  int                cyc, rise_at, gap, hi_len, rises;

  always #50 mclk = ~mclk;

  pwm_modulator uut (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .fast_osc_tick(fast_osc_tick),
    .slow_osc_tick(slow_osc_tick), .pins(pins));

  pwm_pin_model far (.mclk(mclk), .pins(pins), .true_pin(true_pin), .comp_pin(comp_pin),
    .gate_line(gate_line));

  // Fast oscillator pulses every 2 cycles, slow every 5
  always @(posedge mclk) begin
    osc_cnt       <= (osc_cnt == 9) ? 0 : osc_cnt + 1;
    fast_osc_tick <= (osc_cnt % 2 == 0);
    slow_osc_tick <= (osc_cnt % 5 == 0);
  end

  // Rise-to-rise gap and high width of the true waveform
  always @(posedge mclk) begin
    cyc     <= cyc + 1;
    prev_ff <= pins.true_o;
    if (pins.true_o === 1'b1 && prev_ff === 1'b0) begin
      gap     <= cyc - rise_at;
      rise_at <= cyc;
      rises   <= rises + 1;
    end
    if (pins.true_o === 1'b0 && prev_ff === 1'b1) begin
      hi_len <= cyc - rise_at;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic results;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] e);
    checked++;
    if (got !== e) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, e);
    end
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge mclk);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    @(posedge mclk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge mclk);
    rd_en <= 1'b0;
    #1;
    chk(rdata, e);
  endtask

  task automatic setup(input logic [7:0] c, input logic [7:0] d, input logic [7:0] p);
    wr(`OFS_CONTROL, 8'h00);
    wr(`OFS_DUTY, d);
    wr(`OFS_PERIOD, p);
    wr(`OFS_CONTROL, c);
  endtask

  task automatic wait_rises(input int n);
    int t;
    int k;
    t = rises + n;
    k = 0;
    while (rises < t && k < 2000) begin
      @(posedge mclk);
      k++;
    end
    #1;
    chk(k < 2000, 1'b1);
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rd(`OFS_CONTROL, 8'h00);
    rd(`OFS_DUTY, 8'h00);
    rd(`OFS_PERIOD, 8'h00);
    rd(2'h3, 8'h00);
    chk({pins.true_oe_n, pins.comp_oe_n, gate_line}, 3'b110);
    chk(pins.comp_o, 1'b1);
    $display("test reset done");
  endtask

  task automatic t_regs;
    wr(`OFS_DUTY, 8'ha5);
    wr(`OFS_PERIOD, 8'h5a);
    wr(`OFS_CONTROL, 8'hff);
    wr(2'h3, 8'h55);
    rd(`OFS_DUTY, 8'ha5);
    rd(`OFS_PERIOD, 8'h5a);
    rd(`OFS_CONTROL, 8'hfc);
    rd(2'h3, 8'h00);
    wr(`OFS_CONTROL, 8'h00);
    $display("test registers done");
  endtask

  // The first period after enable is cut short, so gaps are judged from the third rise
  task automatic t_wave;
    setup(8'h1c, 8'h01, 8'h03);
    wait_rises(3);
    chk(gap, 16'h0008);
    chk(hi_len, 16'h0002);
    repeat (8) begin
      @(posedge mclk);
      #1;
      chk(comp_pin, !true_pin);
      chk(gate_line, pins.true_o);
      chk(true_pin, pins.true_o);
    end
    $display("test waveform done");
  endtask

  task automatic t_clk;
    for (int d = 0; d < 4; d++) begin
      setup({d[1:0], 6'h1c}, 8'h01, 8'h03);
      wait_rises(3);
      chk(gap, 16'h0008 << d);
    end
    setup(8'h3c, 8'h01, 8'h03);
    wait_rises(3);
    chk(gap, 16'h0014);
    $display("test clocks done");
  endtask

  task automatic t_limits;
    logic [7:0] dv[3] = '{8'h00, 8'h03, 8'h05};
    for (int i = 0; i < 3; i++) begin
      setup(8'h1c, dv[i], 8'h03);
      repeat (20) @(posedge mclk);
      repeat (16) begin
        @(posedge mclk);
        #1;
        chk(pins.true_o, dv[i] != 0);
        chk(comp_pin, dv[i] == 0);
      end
    end
    $display("test limits done");
  endtask

  task automatic t_enables;
    int r;
    setup(8'h18, 8'h01, 8'h03);
    r = rises;
    repeat (20) @(posedge mclk);
    #1;
    chk({pins.true_oe_n, pins.comp_oe_n}, 2'b01);
    chk(rises > r, 1'b1);
    wr(`OFS_CONTROL, 8'h14);
    repeat (3) @(posedge mclk);
    #1;
    chk({pins.true_oe_n, pins.comp_oe_n}, 2'b10);
    wr(`OFS_CONTROL, 8'h0c);
    repeat (3) @(posedge mclk);
    #1;
    r = rises;
    chk({pins.true_oe_n, pins.comp_oe_n, pins.true_o}, 3'b110);
    repeat (40) @(posedge mclk);
    #1;
    chk(rises, r);
    $display("test enables done");
  endtask

  task automatic t_shadow;
    setup(8'h1c, 8'h01, 8'hc8);
    wait_rises(2);
    wr(`OFS_PERIOD, 8'h03);
    wait_rises(1);
    chk(gap, 16'h0192);
    wait_rises(1);
    chk(gap, 16'h0008);
    $display("test shadow done");
  endtask

  initial begin
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    repeat (2) @(posedge mclk);
    t_reset();
    t_regs();
    t_wave();
    t_clk();
    t_limits();
    t_enables();
    t_shadow();
    results();
  end

  initial begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    results();
  end
endmodule

// *** tb/pwm_pin_model.sv ***
// Far side of the modulator: pin pads and the gate line
`timescale 1ns/100ps

module pwm_pin_model
  import pwm_pkg::*;
(
  input  wire logic  mclk,      // System clock
  input  wire pins_s pins,      // Modulator pin bundle
  output logic       true_pin,  // True pad level
  output logic       comp_pin,  // Complement pad level
  output logic       gate_line  // Gate line level
);
  logic wander_ff = 1'b0;

  // No pull on the pads, so an undriven pad wanders every cycle
  always_ff @(posedge mclk) begin
    wander_ff <= ~wander_ff;
  end

  assign true_pin  = pins.true_oe_n ? wander_ff : pins.true_o;
  assign comp_pin  = pins.comp_oe_n ? ~wander_ff : pins.comp_o;
  assign gate_line = pins.gate;
endmodule
